// file: sim/scrp_master.sv
// Purpose: serial master model on a 64 ns shift clock
// Assumes: clock idles low, sample rising, change falling
// Notes:   clock stands still between frames
`timescale 1ns/10ps
`default_nettype none
module scrp_master (
  output var logic sclk,
  output var logic sel_n,
  output var logic si,
  input  wire logic so
);
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    si = 1'b0;
  end
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #32 sclk = 1'b1;
      rx = {rx[30:0], so};
      #32 sclk = 1'b0;
    end
    #32 sel_n = 1'b1;
    si = ~si; // released line must not keep last bit
    #40;
  endtask
endmodule // scrp_master
`default_nettype wire

// file: sim/scrp_port_monitor.sv
// Purpose: port checker for the serial command port
// Assumes: top ports only, one system clock domain
// Notes:   accept taken as at least 2 clk after select rise
`timescale 1ns/10ps
`default_nettype none
module scrp_port_monitor (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 select_low_pin_n,
  input wire logic                 link_so_oe_n,
  input wire logic                 reset_low_input_n,
  input wire scrp_pkg::scrp_cmd_t  last_cmd,
  input wire scrp_pkg::scrp_data_t global_control,
  input wire logic                 parity_fault,
  input wire logic                 watchdog_toggle_bit
);
  import scrp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  sequence s_acc;
    last_cmd.valid;
  endsequence
  sequence s_gwr;
    s_acc ##0 (last_cmd.word.addr == 3'h6);
  endsequence
  property p_hiz; (select_low_pin_n || !reset_low_input_n) |-> link_so_oe_n; endproperty
  property p_drv; (!select_low_pin_n && reset_low_input_n) |-> !link_so_oe_n; endproperty
  property p_pulse; s_acc |=> !last_cmd.valid; endproperty
  property p_after; s_acc |-> $past(select_low_pin_n, 2); endproperty
  property p_par; s_acc |-> !(^last_cmd.word); endproperty
  property p_code; s_acc |-> (last_cmd.word.addr != 3'h3); endproperty
  property p_gbank; s_gwr |-> !last_cmd.word.bank; endproperty
  property p_gwr; s_gwr |-> ##[0:3] (global_control == last_cmd.word.data); endproperty
  property p_wdog; s_acc |-> ##[0:2] (watchdog_toggle_bit == last_cmd.word.wdog); endproperty
  property p_pf; s_acc |-> ##[0:2] !parity_fault; endproperty
  ////////////////////////////////////////////////////////////
  a_hiz: assert property (p_hiz) else $error("so driven while idle");
  a_drv: assert property (p_drv) else $error("so not driven");
  a_pulse: assert property (p_pulse) else $error("accept pulse too long");
  a_after: assert property (p_after) else $error("accept before select rise");
  a_par: assert property (p_par) else $error("odd word accepted");
  a_code: assert property (p_code) else $error("unused code accepted");
  a_gbank: assert property (p_gbank) else $error("global in bank 1");
  a_gwr: assert property (p_gwr) else $error("global not latched");
  a_wdog: assert property (p_wdog) else $error("watchdog bit wrong");
  a_pf: assert property (p_pf) else $error("parity flag after good word");
endmodule // scrp_port_monitor
bind scrp_port scrp_port_monitor mon_u (
  .clk(clk), .rst_n(rst_n), .select_low_pin_n(select_low_pin_n),
  .link_so_oe_n(link_so_oe_n), .reset_low_input_n(reset_low_input_n),
  .last_cmd(last_cmd), .global_control(global_control),
  .parity_fault(parity_fault), .watchdog_toggle_bit(watchdog_toggle_bit)
);
`default_nettype wire

// file: sim/scrp_port_tb_top.sv
// Purpose: self-checking bench of the serial command port
// Assumes: 200 MHz system clock, 64 ns link clock
// Notes:   accepted words queued, checked by watcher
`timescale 1ns/10ps
`default_nettype none
module scrp_port_tb_top;
  import scrp_pkg::*;
  logic        clk, rst_n, sclk, sel_n, si, so, oe_n, rstl_n, sfail, pf, wd;
  wire logic   so_w;
  scrp_state_t fs;
  scrp_cmd_t   lc;
  scrp_data_t  gc, ge;
  logic [15:0] q[$];
  logic [15:0] r, w;
  logic [31:0] rx;
  int          n_fail, n_tests;
  assign so_w = oe_n ? 1'bz : so;
  scrp_master master_u (.sclk(sclk), .sel_n(sel_n), .si(si), .so(so_w));
  scrp_port dut_u (
    .clk(clk), .rst_n(rst_n), .link_sclk(sclk), .select_low_pin_n(sel_n),
    .link_si(si), .link_so(so), .link_so_oe_n(oe_n), .reset_low_input_n(rstl_n),
    .supply_fail(sfail), .fault_state(fs), .last_cmd(lc), .global_control(gc),
    .parity_fault(pf), .watchdog_toggle_bit(wd)
  );
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [15:0] mk(logic a, logic b, logic [2:0] c, logic [9:0] d);
    logic [15:0] x;
    x = {a, 1'b0, b, c, d};
    x[14] = ^x;
    return x;
  endfunction
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // queue filled before the frame: accept lands before xfer returns
  task automatic frame(logic [31:0] tx, int n, logic acc);
    if (acc) q.push_back(tx[15:0]);
    master_u.xfer(tx, n, rx);
    repeat (12) @(posedge clk);
    chk("pending", 16'h0, 16'(q.size()));
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    if (lc.valid === 1'b1) begin
      if (q.size() == 0) chk("extra", 16'h0, 16'hffff);
      else chk("cmd", q.pop_front(), lc.word);
    end
  end
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    rstl_n = 1'b1;
    sfail = 1'b0;
    fs = {10'h2a5, 10'h15a, 10'h3c3, 10'h0f0};
    r = 16'h0063;
    ge = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (5) tick();
    rst_n = 1'b1;
    chk("rst", 16'h0, {4'h0, pf, wd, gc});
    for (int a = 0; a < 16; a++) begin
      r = lfsr(r);
      w = mk(r[15], a[3], a[2:0], {1'b0, r[8:0]});
      if (a == 6) ge = w[9:0];
      frame({16'h0, w}, 16, a[2:0] != 3 && !(a[2:0] == 6 && a[3]));
    end
    frame({16'h0, mk(1'b0, 1'b0, 3'h6, 10'h0ff) ^ 16'h0001}, 16, 1'b0);
    chk("pf", 16'h1, {15'h0, pf});
    frame({16'h0, mk(1'b0, 1'b0, 3'h6, 10'h0ff)}, 15, 1'b0);
    frame({15'h0, mk(1'b0, 1'b0, 3'h6, 10'h0ff), 1'b0}, 17, 1'b0);
    chk("gc", {6'h0, ge}, {6'h0, gc});
    w = mk(1'b1, 1'b0, 3'h0, 10'h007);
    frame({16'h0, w}, 16, 1'b1);
    frame({mk(1'b1, 1'b0, 3'h2, 10'h055), w}, 32, 1'b1);
    chk("rdbk", {3'h4, 3'h7, 10'h2a5}, rx[31:16]);
    chk("chain", mk(1'b1, 1'b0, 3'h2, 10'h055), rx[15:0]);
    for (int k = 0; k < 2; k++) begin
      frame({16'h0, mk(1'b0, 1'b0, 3'h6, k ? 10'h040 : 10'h048)}, 16, 1'b1);
      tick();
      sfail = 1'b1;
      tick();
      sfail = 1'b0;
      repeat (3) tick();
      chk("retain", k ? 16'h0 : 16'h0040, {6'h0, gc});
    end
    frame({16'h0, mk(1'b0, 1'b0, 3'h6, 10'h081)}, 16, 1'b1);
    tick();
    rstl_n = 1'b0;
    frame({16'h0, mk(1'b0, 1'b0, 3'h6, 10'h0ff)}, 16, 1'b0);
    rstl_n = 1'b1;
    repeat (3) tick();
    chk("rstlow", 16'h0, {6'h0, gc});
    stop_test();
  end
endmodule // scrp_port_tb_top
`default_nettype wire

// file: src/scrp_cfg.svh
// Purpose: constants of the serial command register port
// Assumes: 16-bit words, msb first
// Notes:   offsets are the 3-bit address codes of the incoming word
`ifndef SCRP_CFG_SVH
`define SCRP_CFG_SVH
`define SCRP_WORD_BITS      16
`define SCRP_BIT_WDOG       15
`define SCRP_BIT_PARITY     14
`define SCRP_BIT_BANK       13
`define SCRP_ADDR_HI        12
`define SCRP_ADDR_LO        10
`define SCRP_ADDR_RBSEL     3'h0
`define SCRP_ADDR_PWM       3'h1
`define SCRP_ADDR_CONF      3'h2
`define SCRP_ADDR_OVC       3'h4
`define SCRP_ADDR_RETRY     3'h5
`define SCRP_ADDR_GLOBAL    3'h6
`define SCRP_ADDR_CAL       3'h7
`define SCRP_REG_RESET      10'h000
`define SCRP_BIT_PARALLEL   6
`define SCRP_BIT_SUPRETAIN  3
`define SCRP_SEL_STATUS     3'h0
`define SCRP_SEL_FAULT      3'h1
`define SCRP_SEL_DIAG       3'h7
`endif

// file: src/scrp_link.sv
// Purpose: serial shifter on the master's shift clock
// Assumes: shift clock idles low, sample rising, change falling
// Notes:   logic runs only while select is low; frame end closed by select
`timescale 1ns/10ps
`default_nettype none
`include "scrp_cfg.svh"
module scrp_link (
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        si,
  input  wire logic [15:0] load_word,
  output var  logic        so,
  output var  logic [15:0] rx_word,
  output var  logic        len_ok,
  output var  logic        frame_tgl
);
  logic [15:0] rx_q;
  logic [15:0] rx_d;
  logic [15:0] tx_q;
  logic [15:0] tx_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic        first_q;
  logic        first_d;
  logic        so_q;
  logic        tgl_q;
  logic [15:0] cap_q;
  logic        cap_len_q;

  // select high acts as async clear, so no edge is needed outside a frame
  always_comb begin
    rx_d    = {rx_q[14:0], si};
    cnt_d   = 4'(cnt_q + 4'h1);
    first_d = first_q;
    tx_d    = {tx_q[14:0], 1'b0};
    // load word enters only at the first edge, later edges shift it on
    if (first_q && cnt_q == 4'h0) begin
      tx_d = {load_word[14:0], 1'b0};
    end
    if (cnt_q == 4'hf) begin
      first_d = 1'b0;
      tx_d    = rx_d;
    end
  end

  always_ff @(posedge sclk or posedge sel_n) begin
    if (sel_n) begin
      rx_q    <= 16'h0000;
      cnt_q   <= 4'h0;
      first_q <= 1'b1;
      tx_q    <= 16'h0000;
    end else begin
      rx_q    <= rx_d;
      cnt_q   <= cnt_d;
      first_q <= first_d;
      tx_q    <= tx_d;
    end
  end

  // output changes on the falling edge; msb of load word before first edge
  always_ff @(negedge sclk or posedge sel_n) begin
    if (sel_n) begin
      so_q <= 1'b0;
    end else begin
      so_q <= tx_q[15];
    end
  end

  // frame event: toggle on select rise; word and length captured before
  // the select clear wipes the shifter, so they stay static until next rise
  always_ff @(posedge sel_n or negedge rst_n) begin
    if (!rst_n) begin
      tgl_q     <= 1'b0;
      cap_q     <= 16'h0000;
      cap_len_q <= 1'b0;
    end else begin
      tgl_q     <= ~tgl_q;
      cap_q     <= rx_q;
      cap_len_q <= (cnt_q == 4'h0) && !first_q;
    end
  end

  assign so        = (first_q && cnt_q == 4'h0) ? load_word[15] : so_q;
  assign rx_word   = cap_q;
  assign len_ok    = cap_len_q;
  assign frame_tgl = tgl_q;
endmodule // scrp_link
`default_nettype wire

// file: src/scrp_pkg.sv
// Purpose: types of the serial command register port
// Assumes: scrp_cfg.svh constants
// Notes:   none
package scrp_pkg;
  typedef logic [9:0] scrp_data_t;
  typedef struct packed {
    logic       wdog;
    logic       parity;
    logic       bank;
    logic [2:0] addr;
    logic [9:0] data;
  } scrp_word_t;
  typedef struct packed {
    logic       valid;
    scrp_word_t word;
  } scrp_cmd_t;
  typedef struct packed {
    logic [9:0] diag;
    logic [9:0] fault1;
    logic [9:0] fault0;
    logic [9:0] status;
  } scrp_state_t;
endpackage

// file: src/scrp_port.sv
// Purpose: device side of the 16-bit serial command register port
// Assumes: system clock 200 MHz; link clock from the master
// Notes:   frame result crosses by toggle; select level by two flops
`timescale 1ns/10ps
`default_nettype none
`include "scrp_cfg.svh"
module scrp_port (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 link_sclk,
  input  wire logic                 select_low_pin_n,
  input  wire logic                 link_si,
  output logic                      link_so,
  output logic                      link_so_oe_n,
  input  wire logic                 reset_low_input_n,
  input  wire logic                 supply_fail,
  input  wire scrp_pkg::scrp_state_t fault_state,
  output scrp_pkg::scrp_cmd_t       last_cmd,
  output scrp_pkg::scrp_data_t      global_control,
  output logic                      parity_fault,
  output logic                      watchdog_toggle_bit
);
  import scrp_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // parity check shared by the frame decision

  function automatic logic even_ones(input logic [15:0] w);
    even_ones = ~^w;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // link side

  logic [15:0] load_word_q;
  logic [15:0] rx_word;
  logic        len_ok;
  logic        frame_tgl;
  logic        link_so_raw;

  // link held in reset while reset input low, so no frame is seen
  logic link_sel_n;
  assign link_sel_n = select_low_pin_n | ~reset_low_input_n;

  scrp_link u_link (
    .rst_n     (rst_n),
    .sclk      (link_sclk),
    .sel_n     (link_sel_n),
    .si        (link_si),
    .load_word (load_word_q),
    .so        (link_so_raw),
    .rx_word   (rx_word),
    .len_ok    (len_ok),
    .frame_tgl (frame_tgl)
  );

  ////////////////////////////////////////////////////////////////////
  // crossing into the system clock

  logic [2:0] tgl_sync_q;
  logic [2:0] tgl_sync_d;
  logic [1:0] sel_sync_q;
  logic [1:0] sel_sync_d;
  logic [1:0] rlow_sync_q;
  logic [1:0] rlow_sync_d;
  logic       rlow_clr;
  logic       frame_done;

  always_comb begin
    tgl_sync_d  = {tgl_sync_q[1:0], frame_tgl};
    sel_sync_d  = {sel_sync_q[0], link_sel_n};
    rlow_sync_d = {rlow_sync_q[0], reset_low_input_n};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_q  <= 3'h0;
      sel_sync_q  <= 2'h3;
      rlow_sync_q <= 2'h3;
    end else begin
      tgl_sync_q  <= tgl_sync_d;
      sel_sync_q  <= sel_sync_d;
      rlow_sync_q <= rlow_sync_d;
    end
  end

  // reset-low pin clears the stores while it stays low
  assign rlow_clr = ~rlow_sync_q[1];

  // rx_word and len_ok are static once select is high: safe to sample late
  assign frame_done = tgl_sync_q[2] ^ tgl_sync_q[1];

  ////////////////////////////////////////////////////////////////////
  // frame decision

  scrp_word_t word;
  logic       word_ok;
  logic       wr_en;
  logic       rb_bank_q;
  logic       rb_bank_d;
  logic [2:0] rb_sel_q;
  logic [2:0] rb_sel_d;
  logic       pfault_q;
  logic       pfault_d;
  logic       wdog_q;
  logic       wdog_d;
  scrp_cmd_t  cmd_q;
  scrp_cmd_t  cmd_d;

  assign word    = scrp_word_t'(rx_word);
  assign word_ok = frame_done && len_ok && even_ones(rx_word);
  assign wr_en   = word_ok && word.addr != 3'h3 &&
                   !(word.addr == `SCRP_ADDR_GLOBAL && word.bank);

  always_comb begin
    rb_bank_d = rb_bank_q;
    rb_sel_d  = rb_sel_q;
    pfault_d  = pfault_q;
    wdog_d    = wdog_q;
    cmd_d     = cmd_q;
    cmd_d.valid = 1'b0;
    if (frame_done && len_ok) begin
      pfault_d = ~even_ones(rx_word);
    end
    // refused codes raise no accept pulse
    if (wr_en) begin
      wdog_d      = word.wdog;
      cmd_d.valid = 1'b1;
      cmd_d.word  = word;
      if (word.addr == `SCRP_ADDR_RBSEL) begin
        rb_bank_d = word.bank;
        rb_sel_d  = word.data[2:0];
      end
    end
    if (supply_fail || rlow_clr) begin
      rb_bank_d = 1'b0;
      rb_sel_d  = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_bank_q <= 1'b0;
      rb_sel_q  <= 3'h0;
      pfault_q  <= 1'b0;
      wdog_q    <= 1'b0;
      cmd_q     <= '0;
    end else begin
      rb_bank_q <= rb_bank_d;
      rb_sel_q  <= rb_sel_d;
      pfault_q  <= pfault_d;
      wdog_q    <= wdog_d;
      cmd_q     <= cmd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register store and readback word

  scrp_data_t rd_data;
  scrp_data_t gctl;
  logic [9:0] rb_payload;
  logic [15:0] load_d;

  scrp_regfile u_regs (
    .clk         (clk),
    .rst_n       (rst_n),
    .supply_fail (supply_fail),
    .clr         (rlow_clr),
    .wr_en       (wr_en),
    .wr_bank     (word.bank),
    .wr_addr     (word.addr),
    .wr_data     (word.data),
    .rd_bank     (rb_bank_q),
    .rd_addr     (rb_sel_q),
    .rd_data     (rd_data),
    .global_q    (gctl)
  );

  // status, fault and diagnostic selectors come from live state
  always_comb begin
    case (rb_sel_q)
      `SCRP_SEL_STATUS: rb_payload = fault_state.status;
      `SCRP_SEL_FAULT:  rb_payload = rb_bank_q ? fault_state.fault1 : fault_state.fault0;
      `SCRP_SEL_DIAG:   rb_payload = fault_state.diag;
      default:          rb_payload = rd_data;
    endcase
    load_d = {wdog_q, pfault_q, 1'b0, rb_sel_q, rb_payload};
  end

  // refreshed only while the two-flop select copy is high so the link sees a static word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_word_q <= 16'h0000;
    end else if (sel_sync_q[1]) begin
      load_word_q <= load_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_control      <= 10'h000;
      parity_fault        <= 1'b0;
      watchdog_toggle_bit <= 1'b0;
      last_cmd            <= '0;
    end else begin
      global_control      <= gctl;
      parity_fault        <= pfault_q;
      watchdog_toggle_bit <= wdog_q;
      last_cmd            <= cmd_q;
    end
  end

  // pin path is combinational from select: float must follow select at once
  assign link_so      = link_so_raw;
  assign link_so_oe_n = link_sel_n;
endmodule // scrp_port
`default_nettype wire

// file: src/scrp_regfile.sv
// Purpose: banked input register store with registered readback
// Assumes: one write per cycle, system clock domain
// Notes:   parallel bit survives supply failure when retain was set
`timescale 1ns/10ps
`default_nettype none
`include "scrp_cfg.svh"
module scrp_regfile (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              supply_fail,
  input  wire logic              clr,
  input  wire logic              wr_en,
  input  wire logic              wr_bank,
  input  wire logic [2:0]        wr_addr,
  input  wire scrp_pkg::scrp_data_t wr_data,
  input  wire logic              rd_bank,
  input  wire logic [2:0]        rd_addr,
  output var  scrp_pkg::scrp_data_t rd_data,
  output var  scrp_pkg::scrp_data_t global_q
);
  import scrp_pkg::*;
  scrp_data_t mem_q [16];
  scrp_data_t mem_d [16];
  scrp_data_t rd_d;
  logic       retain_q;
  logic       retain_d;

  always_comb begin
    mem_d = mem_q;
    retain_d = retain_q;
    if (clr) begin
      // reset-low clears everything, parallel bit included
      for (int i = 0; i < 16; i++) begin
        mem_d[i] = `SCRP_REG_RESET;
      end
      retain_d = 1'b0;
    end else if (supply_fail) begin
      for (int i = 0; i < 16; i++) begin
        mem_d[i] = `SCRP_REG_RESET;
      end
      if (retain_q) begin
        mem_d[{1'b0, `SCRP_ADDR_GLOBAL}][`SCRP_BIT_PARALLEL] =
          mem_q[{1'b0, `SCRP_ADDR_GLOBAL}][`SCRP_BIT_PARALLEL];
      end
    end else if (wr_en) begin
      mem_d[{wr_bank, wr_addr}] = wr_data;
      if (wr_addr == `SCRP_ADDR_GLOBAL && !wr_bank) begin
        retain_d = wr_data[`SCRP_BIT_SUPRETAIN];
      end
    end
    rd_d = mem_q[{rd_bank, rd_addr}];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= 10'h000;
      end
      retain_q <= 1'b0;
      rd_data  <= 10'h000;
      global_q <= 10'h000;
    end else begin
      mem_q    <= mem_d;
      retain_q <= retain_d;
      rd_data  <= rd_d;
      global_q <= mem_d[{1'b0, `SCRP_ADDR_GLOBAL}];
    end
  end
endmodule // scrp_regfile
`default_nettype wire
